//--- lin_frame_engine.sv
// lin frame engine: header master, response slave, record queue, registers
`timescale 1ns/1ps
`include "lin_consts.svh"

module lin_frame_engine #(
  parameter int QDEPTH = 8
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic lin_in,
  output logic lin_out,
  output logic lin_oe
);

  // pointers wrap naturally, so the depth must be a power of two
  localparam int QAW = $clog2(QDEPTH);
  localparam logic [QAW:0] QFULL = (QAW+1)'(QDEPTH);

  typedef struct packed {
    logic lin_s1;
    logic lin_s2;
    logic lin_oe;
    lin_pkg::ctrl_t ctrl;
    logic [15:0] div;
    logic [2:0] status;
    logic [2:0] mask;
    logic irq;
    logic wreq;
    logic [31:0] rdata;
    logic hdr_pend;
    logic [5:0] hdr_id;
    logic [63:0] stg;
    logic [63:0] valid;
    lin_pkg::mst_st_t m_st;
    lin_pkg::slv_st_t s_st;
    logic [5:0] id;
    logic [3:0] len;
    logic [3:0] idx;
    logic [7:0] sum;
    logic [63:0] data;
    logic waiting;
    logic tx_go;
    logic tx_brk;
    logic [7:0] tx_byte;
    logic [QAW:0] wp;
    logic [QAW:0] rp;
  } state_t;

  state_t s;
  state_t next_s;

  logic [3:0] tbl_len [64];
  logic [63:0] tbl_data [64];
  lin_pkg::rec_t q_mem [QDEPTH];

  logic [1:0] rst_q;
  logic rst_n;
  logic req;
  logic acc;
  logic [31:0] rd;
  logic [2:0] st_set;
  logic [2:0] st_clr;
  logic tbl_we;
  logic push_req;
  logic do_push;
  lin_pkg::rec_t push_rec;
  lin_pkg::rec_t head;
  logic err;
  logic [3:0] err_code;
  logic [QAW:0] used;
  logic [3:0] hit_len;
  logic [3:0] new_len;
  logic tx_busy;
  logic tx_done;
  logic tx_bit;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_ferr;
  logic rx_brk;

  // protected identifier: id plus two parity bits
  function automatic logic [7:0] pid_of(input logic [5:0] id);
    logic p0;
    logic p1;
    p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
    p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
    return {p1, p0, id};
  endfunction

  // checksum step: add with the carry folded back in
  function automatic logic [7:0] csum_add(
    input logic [7:0] a,
    input logic [7:0] b
  );
    logic [8:0] t;
    t = {1'b0, a} + {1'b0, b};
    return t[7:0] + {7'h00, t[8]};
  endfunction

  // length of a response the slave only listens to
  function automatic logic [3:0] sub_len(input logic [5:0] id);
    return id[5] ? (id[4] ? 4'h8 : 4'h4) : 4'h2;
  endfunction

  // queue record builder
  function automatic lin_pkg::rec_t mk_rec(
    input logic [1:0] kind,
    input logic [5:0] id,
    input logic [3:0] len,
    input logic [3:0] code,
    input logic [63:0] data
  );
    lin_pkg::rec_t r;
    r.kind = kind;
    r.id = id;
    r.len = len;
    r.err = code;
    r.data = data;
    return r;
  endfunction

  // release of reset passes two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      rst_q <= 2'h0;
    else
      rst_q <= {rst_q[0], 1'b1};
  end

  assign rst_n = rst_q[1];

  lin_byte_link i_lin_byte_link (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .div(s.div),
    .rx(s.lin_s2),
    .tx_go(s.tx_go),
    .tx_brk(s.tx_brk),
    .tx_byte(s.tx_byte),
    .tx_busy(tx_busy),
    .tx_done(tx_done),
    .tx_bit(tx_bit),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .rx_ferr(rx_ferr),
    .rx_brk(rx_brk)
  );

  always_comb
  begin
    next_s = s;
    st_set = 3'h0;
    st_clr = 3'h0;
    tbl_we = 1'b0;
    push_req = 1'b0;
    push_rec = '0;
    err = 1'b0;
    err_code = 4'h0;
    next_s.tx_go = 1'b0;
    next_s.tx_brk = 1'b0;
    next_s.lin_s1 = lin_in;
    next_s.lin_s2 = s.lin_s1;
    used = s.wp - s.rp;
    head = (used == '0) ? '0 : q_mem[s.rp[QAW-1:0]];
    hit_len = tbl_len[rx_byte[5:0]];
    new_len = (avs_writedata[3:0] > 4'h8) ? 4'h8 : avs_writedata[3:0];
    req = avs_read | avs_write;
    // a partial-word write is dropped; the registers are word wide
    acc = avs_write & ~s.wreq & (avs_byteenable == 4'hF);

    // read mux, registered one cycle after the request appears
    rd = 32'h0000_0000;
    case (avs_address)
      `REG_CTRL: rd[`CTRL_W-1:0] = s.ctrl;
      `REG_BAUD: rd[15:0] = s.div;
      `REG_STATUS: rd[2:0] = s.status;
      `REG_MASK: rd[2:0] = s.mask;
      `REG_HDR: rd[6:0] = {s.hdr_pend, s.hdr_id};
      `REG_RESP_LO: rd = s.stg[31:0];
      `REG_RESP_HI: rd = s.stg[63:32];
      `REG_QCNT: rd[QAW:0] = used;
      `REG_REC_INFO: rd[15:0] = {head.kind, head.id, head.len, head.err};
      `REG_REC_LO: rd = head.data[31:0];
      `REG_REC_HI: rd = head.data[63:32];
      default: rd = 32'h0000_0000;
    endcase
    next_s.wreq = ~(req & s.wreq);
    if (req & s.wreq)
      next_s.rdata = rd;

    // register writes take effect on the edge after the wait ends
    if (acc)
    begin
      case (avs_address)
        `REG_CTRL: next_s.ctrl = avs_writedata[`CTRL_W-1:0];
        `REG_BAUD: next_s.div = avs_writedata[15:0];
        `REG_STATUS: st_clr = avs_writedata[2:0];
        `REG_MASK: next_s.mask = avs_writedata[2:0];
        `REG_HDR:
        begin
          // a header while one is still pending is refused
          if (s.ctrl.run && s.ctrl.master && !s.hdr_pend)
          begin
            next_s.hdr_pend = 1'b1;
            next_s.hdr_id = avs_writedata[5:0];
          end
        end
        `REG_RESP_LO: next_s.stg[31:0] = avs_writedata;
        `REG_RESP_HI: next_s.stg[63:32] = avs_writedata;
        `REG_RESP_CTL:
        begin
          tbl_we = 1'b1;
          next_s.valid[avs_writedata[13:8]] = 1'b1;
          st_set[`ST_WROK] = 1'b1;
        end
        `REG_POP:
        begin
          if (used != '0)
            next_s.rp = s.rp + 1'b1;
        end
        default: ;
      endcase
    end

    // master task: break, sync byte, protected id
    unique case (s.m_st)
      lin_pkg::M_IDLE:
      begin
        if (s.hdr_pend && s.ctrl.master && s.s_st == lin_pkg::S_IDLE
            && !tx_busy && !s.tx_go)
        begin
          next_s.tx_go = 1'b1;
          next_s.tx_brk = 1'b1;
          next_s.m_st = lin_pkg::M_BRK;
        end
      end
      lin_pkg::M_BRK:
      begin
        if (tx_done)
        begin
          next_s.tx_go = 1'b1;
          next_s.tx_byte = `SYNC_BYTE;
          next_s.m_st = lin_pkg::M_SYNC;
        end
      end
      lin_pkg::M_SYNC:
      begin
        if (tx_done)
        begin
          next_s.tx_go = 1'b1;
          next_s.tx_byte = pid_of(s.hdr_id);
          next_s.m_st = lin_pkg::M_PID;
        end
      end
      lin_pkg::M_PID:
      begin
        if (tx_done)
        begin
          next_s.hdr_pend = 1'b0;
          next_s.m_st = lin_pkg::M_IDLE;
        end
      end
    endcase

    // slave task; a line fault mid frame ends the frame
    if (s.s_st != lin_pkg::S_IDLE && (rx_ferr || rx_brk))
    begin
      err = 1'b1;
      err_code = rx_brk ? `ERR_BRK : `ERR_FRAME;
    end
    else
    begin
      unique case (s.s_st)
        lin_pkg::S_IDLE:
        begin
          if (rx_brk)
            next_s.s_st = lin_pkg::S_SYNC;
        end
        lin_pkg::S_SYNC:
        begin
          if (rx_valid && rx_byte == `SYNC_BYTE)
            next_s.s_st = lin_pkg::S_PID;
          else if (rx_valid)
          begin
            err = 1'b1;
            err_code = `ERR_SYNC;
          end
        end
        lin_pkg::S_PID:
        begin
          if (rx_valid && rx_byte != pid_of(rx_byte[5:0]))
          begin
            err = 1'b1;
            err_code = `ERR_PAR;
          end
          else if (rx_valid)
          begin
            next_s.id = rx_byte[5:0];
            next_s.idx = 4'h0;
            next_s.waiting = 1'b0;
            next_s.data = 64'h0000_0000_0000_0000;
            // enhanced sum covers the pid, except diagnostic frames
            next_s.sum = (s.ctrl.enh && rx_byte[5:0] < `DIAG_ID)
                         ? rx_byte : 8'h00;
            // length zero or no entry: listen only
            if (s.valid[rx_byte[5:0]] && hit_len != 4'h0)
            begin
              next_s.len = hit_len;
              next_s.data = tbl_data[rx_byte[5:0]];
              next_s.s_st = lin_pkg::S_TX;
            end
            else
            begin
              next_s.len = sub_len(rx_byte[5:0]);
              next_s.s_st = lin_pkg::S_RX;
            end
          end
        end
        lin_pkg::S_RX:
        begin
          if (rx_valid && s.idx != s.len)
          begin
            next_s.data[{s.idx[2:0], 3'h0} +: 8] = rx_byte;
            next_s.sum = csum_add(s.sum, rx_byte);
            next_s.idx = s.idx + 4'h1;
          end
          else if (rx_valid && rx_byte != ~s.sum)
          begin
            err = 1'b1;
            err_code = `ERR_CSUM;
          end
          else if (rx_valid)
          begin
            push_req = 1'b1;
            push_rec = mk_rec(`REC_FULL, s.id, s.len, 4'h0, s.data);
            next_s.s_st = lin_pkg::S_IDLE;
          end
        end
        lin_pkg::S_TX:
        begin
          // next byte leaves only once the line is free again
          if (!s.waiting && !tx_busy && !s.tx_go)
          begin
            next_s.tx_go = 1'b1;
            next_s.tx_byte = (s.idx == s.len) ? ~s.sum
                             : s.data[{s.idx[2:0], 3'h0} +: 8];
            next_s.waiting = 1'b1;
          end
          else if (s.waiting && rx_valid && rx_byte != s.tx_byte)
          begin
            err = 1'b1; // readback differs: another node drove the bus
            err_code = `ERR_BIT;
          end
          else if (s.waiting && rx_valid && s.idx == s.len)
          begin
            push_req = s.ctrl.self_rx;
            push_rec = mk_rec(`REC_FULL, s.id, s.len, 4'h0, s.data);
            next_s.s_st = lin_pkg::S_IDLE;
          end
          else if (s.waiting && rx_valid)
          begin
            next_s.sum = csum_add(s.sum, s.tx_byte);
            next_s.idx = s.idx + 4'h1;
            next_s.waiting = 1'b0;
          end
        end
        default: next_s.s_st = lin_pkg::S_IDLE;
      endcase
    end

    // only one error per frame: the task leaves the frame at once
    if (err)
    begin
      push_req = s.ctrl.log_err;
      push_rec = mk_rec(`REC_ERR, s.id, 4'h0, err_code,
                        64'h0000_0000_0000_0000);
      next_s.waiting = 1'b0;
      next_s.s_st = rx_brk ? lin_pkg::S_SYNC : lin_pkg::S_IDLE;
    end

    // stopped: both tasks idle, pending header dropped
    if (!s.ctrl.run)
    begin
      next_s.m_st = lin_pkg::M_IDLE;
      next_s.s_st = lin_pkg::S_IDLE;
      next_s.hdr_pend = 1'b0;
      push_req = 1'b0;
    end

    // queue push; a full queue drops the record and flags overflow
    do_push = push_req && (used != QFULL);
    if (do_push)
    begin
      next_s.wp = s.wp + 1'b1;
      st_set[`ST_RDAV] = 1'b1;
    end
    st_set[`ST_OVF] = push_req && (used == QFULL);

    // a set in the same cycle as its clear wins
    next_s.status = (s.status & ~st_clr) | st_set;
    next_s.irq = |(next_s.status & next_s.mask);
    next_s.lin_oe = ~tx_bit;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.wreq <= 1'b1;
      s.lin_s1 <= 1'b1;
      s.lin_s2 <= 1'b1;
      s.div <= `BAUD_DIV_DEF;
    end
    else
      s <= next_s;
  end

  // table and queue storage need no reset; valid bits and pointers guard
  always_ff @(posedge ref_clk)
  begin
    if (tbl_we)
    begin
      tbl_len[avs_writedata[13:8]] <= new_len;
      tbl_data[avs_writedata[13:8]] <= s.stg;
    end
    if (do_push)
      q_mem[s.wp[QAW-1:0]] <= push_rec;
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.wreq;
  assign irq = s.irq;
  assign lin_oe = s.lin_oe;
  assign lin_out = 1'b0; // open drain: only ever pulls dominant
endmodule // lin_frame_engine

//--- lin_consts.svh
// register map, field positions and timing constants of the lin engine
// Overview of operation
// - master mode: a header request sends break, sync and protected id
// - every header: look up the id entry, then receive or publish
// - entry length zero means receive; its data bytes are ignored
// - entry length one to eight publishes exactly that many bytes
// - each good received response is logged as a full record
// - own published responses are logged only with self-reception on
// - with error logging on, first error of a frame is logged
// - after an error the slave drops the frame, waits for a header
// - any record push sets the read-available flag
// - committing a response entry sets the write-success flag
// - entries may be rewritten while running; next header uses them
// - slave mode sends no headers, only answers external ones
// - an id with no entry defaults to receiving
`ifndef LIN_CONSTS_SVH
`define LIN_CONSTS_SVH
`define CLK_HZ 10000000
`define BAUD_BPS 19200
`define BAUD_DIV_DEF 16'(`CLK_HZ / `BAUD_BPS)
`define BRK_TOTAL 4'hE
`define CHAR_BITS 4'hA
`define SYNC_BYTE 8'h55
`define DIAG_ID 6'h3C
`define REG_CTRL 6'h00
`define REG_BAUD 6'h04
`define REG_STATUS 6'h08
`define REG_MASK 6'h0C
`define REG_HDR 6'h10
`define REG_RESP_LO 6'h14
`define REG_RESP_HI 6'h18
`define REG_RESP_CTL 6'h1C
`define REG_QCNT 6'h20
`define REG_REC_INFO 6'h24
`define REG_REC_LO 6'h28
`define REG_REC_HI 6'h2C
`define REG_POP 6'h30
`define CTRL_W 5
`define ST_RDAV 0
`define ST_WROK 1
`define ST_OVF 2
`define REC_FULL 2'h1
`define REC_ERR 2'h2
`define ERR_SYNC 4'h1
`define ERR_PAR 4'h2
`define ERR_BIT 4'h3
`define ERR_FRAME 4'h4
`define ERR_CSUM 4'h5
`define ERR_BRK 4'h6
`endif

//--- lin_pkg.sv
// shared types of the lin frame engine
package lin_pkg;
  typedef enum logic [1:0] {M_IDLE, M_BRK, M_SYNC, M_PID} mst_st_t;
  typedef enum logic [2:0] {S_IDLE, S_SYNC, S_PID, S_RX, S_TX} slv_st_t;
  // control bits, run is bit 0
  typedef struct packed {
    logic log_err;
    logic self_rx;
    logic enh;
    logic master;
    logic run;
  } ctrl_t;
  // one queue record: full frame or error
  typedef struct packed {
    logic [1:0] kind;
    logic [5:0] id;
    logic [3:0] len;
    logic [3:0] err;
    logic [63:0] data;
  } rec_t;
endpackage

//--- lin_byte_link.sv
// bit timing, break and byte transceiver on the lin line
`timescale 1ns/1ps
module lin_byte_link
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] div,
  input wire logic rx,
  input wire logic tx_go,
  input wire logic tx_brk,
  input wire logic [7:0] tx_byte,
  output logic tx_busy,
  output logic tx_done,
  output logic tx_bit,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_ferr,
  output logic rx_brk
);
  typedef struct packed {
    logic [15:0] tcnt;
    logic [3:0] tbits;
    logic [13:0] tsh;
    logic tbusy;
    logic tdone;
    logic tbit;
    logic [15:0] rcnt;
    logic [3:0] rn;
    logic [7:0] rsh;
    logic ract;
    logic rhold;
    logic rvalid;
    logic rferr;
    logic rbrk;
  } link_t;

  link_t s;
  link_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.tdone = 1'b0;
    next_s.rvalid = 1'b0;
    next_s.rferr = 1'b0;
    next_s.rbrk = 1'b0;
    // transmit lsb first; a break is 13 dominant bits plus a delimiter
    if (!s.tbusy)
    begin
      if (tx_go)
      begin
        next_s.tbusy = 1'b1;
        next_s.tcnt = div - 16'h0001;
        next_s.tsh = tx_brk ? {1'b1, 13'h0000}
                            : {4'hF, 1'b1, tx_byte, 1'b0};
        next_s.tbits = tx_brk ? `BRK_TOTAL : `CHAR_BITS;
      end
    end
    else if (s.tcnt == 16'h0000)
    begin
      next_s.tcnt = div - 16'h0001;
      next_s.tsh = {1'b1, s.tsh[13:1]};
      next_s.tbits = s.tbits - 4'h1;
      if (s.tbits == 4'h1)
      begin
        next_s.tbusy = 1'b0;
        next_s.tdone = 1'b1;
      end
    end
    else
      next_s.tcnt = s.tcnt - 16'h0001;
    next_s.tbit = next_s.tbusy ? next_s.tsh[0] : 1'b1;
    // receive: sample mid bit; a dominant stop bit holds until recessive
    if (s.rhold)
      next_s.rhold = ~rx;
    else if (!s.ract)
    begin
      if (!rx)
      begin
        next_s.ract = 1'b1;
        next_s.rcnt = {1'b0, div[15:1]};
        next_s.rn = 4'h0;
      end
    end
    else if (s.rcnt == 16'h0000)
    begin
      next_s.rcnt = div - 16'h0001;
      next_s.rn = s.rn + 4'h1;
      if (s.rn == 4'h0)
        next_s.ract = ~rx; // glitch shorter than half a bit is dropped
      else if (s.rn != 4'h9)
        next_s.rsh = {rx, s.rsh[7:1]};
      else
      begin
        next_s.ract = 1'b0;
        if (rx)
          next_s.rvalid = 1'b1;
        else
        begin
          next_s.rhold = 1'b1;
          next_s.rbrk = (s.rsh == 8'h00);
          next_s.rferr = (s.rsh != 8'h00);
        end
      end
    end
    else
      next_s.rcnt = s.rcnt - 16'h0001;
  end

  // idle line is recessive from reset onward
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.tbit <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign tx_busy = s.tbusy;
  assign tx_done = s.tdone;
  assign tx_bit = s.tbit;
  assign rx_valid = s.rvalid;
  assign rx_byte = s.rsh;
  assign rx_ferr = s.rferr;
  assign rx_brk = s.rbrk;
endmodule // lin_byte_link

//--- lin_frame_engine_assertions.sv
// port-level assertions of the lin frame engine, bound to its top module
`timescale 1ns/1ps
module lin_frame_engine_assertions #(
  parameter int QDEPTH = 8
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic lin_in,
  input wire logic lin_out,
  input wire logic lin_oe
);
  logic [4:0] ctrl_sh;
  logic [15:0] baud_sh;
  logic [2:0] mask_sh;
  logic [19:0] oe_cnt;
  wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
  // shadow of host settings; the line run length is judged in bit times
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_sh <= 5'h00;
      baud_sh <= 16'h0208;
      mask_sh <= 3'h0;
      oe_cnt <= 20'h0_0000;
    end
    else
    begin
      oe_cnt <= lin_oe ? oe_cnt + 20'h0_0001 : 20'h0_0000;
      if (wr_ok && avs_address == 6'h00)
        ctrl_sh <= avs_writedata[4:0];
      if (wr_ok && avs_address == 6'h04)
        baud_sh <= avs_writedata[15:0];
      if (wr_ok && avs_address == 6'h0C)
        mask_sh <= avs_writedata[2:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wait_pulse_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  wait_answer_a:
    assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("access not answered next cycle");
  read_hold_a:
    assert property (!avs_read && !avs_write |=> $stable(avs_readdata))
    else $error("read data moved without an access");
  unmapped_zero_a:
    assert property (avs_read && !avs_waitrequest && (avs_address >= 6'h34
      || avs_address == 6'h1C) |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped or write-only place read nonzero");
  open_drain_a:
    assert property (!lin_out) else $error("lin data not dominant level");
  hdr_start_a:
    assert property (wr_ok && avs_address == 6'h10 && ctrl_sh[1:0] == 2'h3
      && !lin_oe |=> ##[0:200] lin_oe) else $error("header not started");
  slave_quiet_a:
    assert property (!ctrl_sh[1] |-> oe_cnt <= 20'(baud_sh) * 20'h0_000A)
    else $error("break driven in slave mode");
  brk_len_a:
    assert property (ctrl_sh[1] |-> oe_cnt <= 20'(baud_sh) * 20'h0_000D)
    else $error("dominant run longer than a break");
  irq_mask_a:
    assert property ($rose(irq) |-> mask_sh != 3'h0)
    else $error("interrupt raised while fully masked");
  irq_off_a:
    assert property (mask_sh == 3'h0 [*2] |-> !irq)
    else $error("interrupt stays high with mask clear");
endmodule // lin_frame_engine_assertions

bind lin_frame_engine lin_frame_engine_assertions #(.QDEPTH(QDEPTH))
  i_lin_frame_engine_assertions (.ref_clk(ref_clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq(irq), .lin_in(lin_in), .lin_out(lin_out), .lin_oe(lin_oe));

//--- lin_node_model.sv
// external lin node: drives headers and responses, samples the bus
`timescale 1ns/1ps
module lin_node_model #(
  parameter int BIT = 8
)
(
  input wire logic ref_clk,
  input wire logic bus,
  output logic node_oe
);
  initial node_oe = 1'b0;
  function automatic logic [7:0] pid_of(input logic [5:0] id);
    return {~^{id[1], id[3], id[4], id[5]}, ^{id[0], id[1], id[2], id[4]}, id};
  endfunction
  // classic checksum: sum with carry wrap, inverted
  function automatic logic [7:0] csum(input logic [63:0] d, input int n);
    int s;
    s = 0;
    for (int i = 0; i < n; i++)
    begin
      s = s + d[8*i+:8];
      if (s > 255)
        s = s - 255;
    end
    return ~8'(s);
  endfunction
  task automatic put_bit(input logic v);
    node_oe <= ~v;
    repeat (BIT) @(posedge ref_clk);
  endtask
  task automatic put_byte(input logic [7:0] v);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++)
      put_bit(v[i]);
    put_bit(1'b1);
  endtask
  // a bad sync value lets the bench inject a header fault
  task automatic put_hdr(input logic [5:0] id, input logic [7:0] sync);
    repeat (13) put_bit(1'b0);
    put_bit(1'b1);
    put_byte(sync);
    put_byte(pid_of(id));
  endtask
  task automatic put_resp(input logic [63:0] d, input int n);
    for (int i = 0; i < n; i++)
      put_byte(d[8*i+:8]);
    put_byte(csum(d, n));
  endtask
  // waits for a start edge, then samples mid-bit
  task automatic get_byte(output logic [7:0] v);
    while (bus !== 1'b1) @(posedge ref_clk);
    while (bus !== 1'b0) @(posedge ref_clk);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge ref_clk);
      v[i] = bus;
    end
  endtask
endmodule // lin_node_model

//--- lin_frame_engine_tb.sv
// self-checking bench: host register traffic against an external lin node
`timescale 1ns/1ps
`include "lin_consts.svh"
module lin_frame_engine_tb;
  localparam int BIT = 8;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd;
  logic [7:0] b;
  logic avs_waitrequest, irq, lin_out, lin_oe, node_oe, bus;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0, k;
  // pulled-up bus: any dominant driver wins
  assign bus = (lin_oe ? lin_out : 1'b1) & ~node_oe;
  always #50 ref_clk = ~ref_clk;
  lin_frame_engine #(.QDEPTH(8)) i_lin_frame_engine (.ref_clk(ref_clk),
    .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .lin_in(bus),
    .lin_out(lin_out), .lin_oe(lin_oe));
  lin_node_model #(.BIT(BIT)) i_lin_node_model (.ref_clk(ref_clk),
    .bus(bus), .node_oe(node_oe));
  task automatic report_and_stop();
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // a hung wait counts as a mismatch
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_fail = n_fail + 1;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    bus_rd(a, rd);
    chk(rd, exp, "register read");
  endtask
  task automatic wait_rdav();
    rd = 32'h0000_0000;
    while (rd[0] !== 1'b1)
      bus_rd(`REG_STATUS, rd);
  endtask
  // bytes past the logged length are not compared
  task automatic rec_chk(input logic [5:0] id, input logic [3:0] n,
    input logic [63:0] d);
    logic [63:0] m;
    m = (64'h0000_0000_0000_0001 << (8 * n)) - 64'h0000_0000_0000_0001;
    wait_rdav();
    rd_chk(`REG_REC_INFO, {16'h0000, `REC_FULL, id, n, 4'h0});
    bus_rd(`REG_REC_LO, rd);
    chk(rd & m[31:0], d[31:0], "record low bytes");
    bus_rd(`REG_REC_HI, rd);
    chk(rd & m[63:32], d[63:32], "record high bytes");
    bus_wr(`REG_POP, 32'h0000_0000);
    bus_wr(`REG_STATUS, 32'h0000_0001);
  endtask
  task automatic t_reset();
    rd_chk(`REG_BAUD, 32'h0000_0208);
    rd_chk(`REG_CTRL, 32'h0000_0000);
    rd_chk(`REG_STATUS, 32'h0000_0000);
    rd_chk(6'h3C, 32'h0000_0000);
    avs_byteenable <= 4'h3;
    bus_wr(`REG_BAUD, BIT);
    avs_byteenable <= 4'hF;
    rd_chk(`REG_BAUD, 32'h0000_0208);
    bus_wr(`REG_BAUD, BIT);
    bus_wr(`REG_CTRL, 32'h0000_0011);
    bus_wr(`REG_HDR, 32'h0000_0021);
    rd_chk(`REG_HDR, 32'h0000_0000);
    bus_wr(`REG_MASK, 32'h0000_0001);
  endtask
  task automatic t_subscribe();
    i_lin_node_model.put_hdr(6'h05, 8'h55);
    i_lin_node_model.put_resp(64'h0000_0000_0000_3CA5, 2);
    wait_rdav();
    chk(32'(irq), 32'h0000_0001, "interrupt raised");
    rec_chk(6'h05, 4'h2, 64'h0000_0000_0000_3CA5);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0000_0000, "interrupt cleared");
  endtask
  task automatic t_publish();
    bus_wr(`REG_RESP_LO, 32'h4433_2211);
    bus_wr(`REG_RESP_HI, 32'h8877_6655);
    bus_wr(`REG_RESP_CTL, 32'h0000_0703);
    rd_chk(`REG_STATUS, 32'h0000_0002);
    bus_wr(`REG_STATUS, 32'h0000_0002);
    i_lin_node_model.put_hdr(6'h07, 8'h55);
    for (int i = 0; i < 3; i++)
    begin
      i_lin_node_model.get_byte(b);
      chk(32'(b), 32'(8'h11 * (i + 1)), "published byte");
    end
    i_lin_node_model.get_byte(b);
    chk(32'(b), 32'h0000_0099, "csum");
    repeat (4 * BIT) @(posedge ref_clk);
    rd_chk(`REG_QCNT, 32'h0000_0000);
    bus_wr(`REG_CTRL, 32'h0000_0019);
    i_lin_node_model.put_hdr(6'h07, 8'h55);
    rec_chk(6'h07, 4'h3, 64'h0000_0000_0033_2211);
    bus_wr(`REG_RESP_CTL, 32'h0000_0700);
    i_lin_node_model.put_hdr(6'h07, 8'h55);
    i_lin_node_model.put_resp(64'h0000_0000_0000_BEEF, 2);
    rec_chk(6'h07, 4'h2, 64'h0000_0000_0000_BEEF);
  endtask
  // bad sync: one error record, then the next frame in order
  task automatic t_error();
    i_lin_node_model.put_hdr(6'h06, 8'h54);
    i_lin_node_model.put_hdr(6'h06, 8'h55);
    i_lin_node_model.put_resp(64'h0000_0000_0000_1234, 2);
    repeat (4 * BIT) @(posedge ref_clk);
    rd_chk(`REG_QCNT, 32'h0000_0002);
    bus_rd(`REG_REC_INFO, rd);
    chk(rd & 32'h0000_C0FF, {`REC_ERR, 10'h000, `ERR_SYNC}, "err");
    bus_wr(`REG_POP, 32'h0000_0000);
    rec_chk(6'h06, 4'h2, 64'h0000_0000_0000_1234);
  endtask
  task automatic t_master();
    bus_wr(`REG_CTRL, 32'h0000_0013);
    bus_wr(`REG_HDR, 32'h0000_0021);
    k = 0;
    while (bus !== 1'b0) @(posedge ref_clk);
    while (bus === 1'b0)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk(32'(k), 32'(13 * BIT), "break length");
    i_lin_node_model.get_byte(b);
    chk(32'(b), 32'(`SYNC_BYTE), "sync byte");
    i_lin_node_model.get_byte(b);
    chk(32'(b), 32'(i_lin_node_model.pid_of(6'h21)), "id byte");
    repeat (2 * BIT) @(posedge ref_clk);
    i_lin_node_model.put_resp(64'h0000_0000_DDCC_BBAA, 4);
    rec_chk(6'h21, 4'h4, 64'h0000_0000_DDCC_BBAA);
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_subscribe();
    t_publish();
    t_error();
    t_master();
    report_and_stop();
  end
endmodule // lin_frame_engine_tb
